/* srcl_consts.vh */
// Constants for the serial configuration ROM loader
`ifndef SRCL_CONSTS_VH
`define SRCL_CONSTS_VH
// Serial ROM opcodes (start bit excluded), two bits each
`define SRCL_OP_READ 2'h2
`define SRCL_OP_WRITE 2'h1
`define SRCL_OP_ERASE 2'h3
`define SRCL_OP_EXT 2'h0
// Extended opcode upper address bits for write enable
`define SRCL_EWEN_ADDR 9'h180
// Image byte offsets
`define SRCL_SIG_ADDR 9'h000
`define SRCL_SIG_VALUE 8'hA5
`define SRCL_MAC_ADDR 9'h001
`define SRCL_FLAGS_ADDR 9'h009
`define SRCL_STR_FIRST 9'h00C
`define SRCL_STR_LAST 9'h015
`define SRCL_HSCFG_LEN 9'h018
`define SRCL_FSCFG_LEN 9'h01C
`define SRCL_HUB_FIRST 9'h020
`define SRCL_HUB_LAST 9'h039
`define SRCL_LOAD_LAST 9'h039
// Descriptor lengths
`define SRCL_DESC_LEN 8'h12
// Configuration flag bit positions
`define SRCL_FLAG_WAKE 2
`define SRCL_FLAG_SELF 0
// Host command codes
`define SRCL_CMD_READ 2'h0
`define SRCL_CMD_WRITE 2'h1
`define SRCL_CMD_ERASE 2'h2
// Serial clock half period and write busy timeout
`define SRCL_HALF_NS 500
`define SRCL_CLK_NS 10
`define SRCL_HALF_CYC ((`SRCL_HALF_NS + `SRCL_CLK_NS - 1) / `SRCL_CLK_NS)
`define SRCL_BUSY_MS 10
`define SRCL_BUSY_CYC (`SRCL_BUSY_MS * 100000)
`endif

/* srcl_shift.v */
// Bit engine for one serial ROM access
`timescale 1ns/1ps
`include "srcl_consts.vh"
module srcl_shift #(
	parameter HALF_CYC = `SRCL_HALF_CYC,
	parameter BUSY_CYC = `SRCL_BUSY_CYC
) (
	input wire clk,
	input wire reset,
	input wire start,
	input wire [1:0] opcode,
	input wire [8:0] addr,
	input wire [7:0] wdata,
	input wire wait_busy,
	output wire done,
	output reg [7:0] rdata_ff,
	output reg timeout_ff,
	output reg rom_cs_ff,
	output reg rom_clk_ff,
	output reg rom_do_ff,
	input wire rom_di
);
	localparam S_IDLE = 2'h0;
	localparam S_SHIFT = 2'h1;
	localparam S_GAP = 2'h2;
	localparam S_BUSY = 2'h3;
	reg [1:0] state_ff;
	reg [20:0] cnt_ff;
	reg [5:0] bit_ff;
	reg [19:0] sreg_ff;
	reg [7:0] rcap_ff;
	reg busy_ff;
	reg wait_ff;
	reg di_s1_ff;
	reg di_s2_ff;
	wire tick = (cnt_ff == 21'h000000);
	// Data input crosses from the pin, two stages
	always @(posedge clk) begin
		di_s1_ff <= rom_di;
		di_s2_ff <= di_s1_ff;
	end
	assign done = (state_ff == S_IDLE) && !busy_ff;
	// Frame: start, opcode, nine address bits, eight data bits
	always @(posedge clk) begin
		if (reset) begin
			state_ff <= S_IDLE;
			cnt_ff <= 21'h000000;
			bit_ff <= 6'h00;
			sreg_ff <= 20'h00000;
			rcap_ff <= 8'h00;
			rdata_ff <= 8'h00;
			wait_ff <= 1'b0;
			busy_ff <= 1'b0;
			timeout_ff <= 1'b0;
			rom_cs_ff <= 1'b0;
			rom_clk_ff <= 1'b0;
			rom_do_ff <= 1'b0;
		end else begin
			busy_ff <= 1'b0;
			case (state_ff)
			S_IDLE: begin
				if (start) begin
					sreg_ff <= {1'b1, opcode, addr, wdata};
					// Busy wait latched now; the requester moves on
					wait_ff <= wait_busy;
					bit_ff <= 6'h28;
					cnt_ff <= HALF_CYC[20:0];
					rom_cs_ff <= 1'b1;
					busy_ff <= 1'b1;
					timeout_ff <= 1'b0;
					state_ff <= S_SHIFT;
				end
			end
			S_SHIFT: begin
				busy_ff <= 1'b1;
				cnt_ff <= tick ? HALF_CYC[20:0] : cnt_ff - 21'h000001;
				if (tick) begin
					rom_clk_ff <= bit_ff[0];
					if (bit_ff[0]) begin
						// Rising edge: sample returning data
						rcap_ff <= {rcap_ff[6:0], di_s2_ff};
					end else begin
						rom_do_ff <= sreg_ff[19];
						sreg_ff <= {sreg_ff[18:0], 1'b0};
					end
					if (bit_ff == 6'h00) begin
						rom_cs_ff <= 1'b0;
						rom_do_ff <= 1'b0;
						state_ff <= S_GAP;
					end else begin
						bit_ff <= bit_ff - 6'h01;
					end
				end
			end
			S_GAP: begin
				busy_ff <= 1'b1;
				rdata_ff <= rcap_ff;
				cnt_ff <= BUSY_CYC[20:0];
				// Programming cycles report ready on data out
				rom_cs_ff <= wait_ff;
				state_ff <= wait_ff ? S_BUSY : S_IDLE;
			end
			S_BUSY: begin
				busy_ff <= 1'b1;
				cnt_ff <= cnt_ff - 21'h000001;
				// First samples still show the deselected line, so they are skipped
				if ((di_s2_ff && cnt_ff < BUSY_CYC[20:0] - 21'h000002) || cnt_ff == 21'h000000) begin
					timeout_ff <= (cnt_ff == 21'h000000) && !di_s2_ff;
					rom_cs_ff <= 1'b0;
					state_ff <= S_IDLE;
				end
			end
			default: state_ff <= S_IDLE;
			endcase
		end
	end
endmodule

/* srcl_loader.v */
// Serial configuration ROM loader and host access controller
`timescale 1ns/1ps
`include "srcl_consts.vh"
// Operation
// - Nine address bits are shifted per access, covering 256 and 512 byte parts.
// - Loaded station address feeds the high and low address registers.
// - Every system reset starts an automatic load from a valid image.
// - USB transactions are refused until the post-reset load finishes.
// - Host may read, write and erase memory bytes.
// - Descriptor offsets are in 16-bit words, doubled to byte addresses.
// - Zero length means item absent; built-in default is used.
// - Without configuration descriptor, attributes and power come from flags.
// - All string lengths zero means no language identifier is reported.
// - Hub parameters come from image bytes 20h to 39h.
// - Without a valid image, hub parameters take built-in defaults.
module srcl_loader #(
	parameter HALF_CYC = `SRCL_HALF_CYC,
	parameter BUSY_CYC = `SRCL_BUSY_CYC,
	parameter [255:0] HUB_DEFAULT = 256'h0
) (
	input wire clk,
	input wire reset,
	input wire host_req,
	input wire [1:0] host_cmd,
	input wire [8:0] host_addr,
	input wire [7:0] host_wdata,
	output wire host_ready,
	output reg host_done_ff,
	output reg [7:0] host_rdata_ff,
	output reg host_err_ff,
	output reg load_busy_ff,
	output wire usb_accept,
	output reg image_valid_ff,
	output reg [31:0] station_addr_low_reg,
	output reg [15:0] station_addr_high_reg,
	output reg [7:0] cfg_flags_ff,
	output reg [7:0] cfg_attributes_ff,
	output reg [7:0] cfg_max_power_ff,
	output reg lang_id_supported_ff,
	output reg [8:0] hs_dev_desc_addr_ff,
	output reg [8:0] hs_cfg_desc_addr_ff,
	output reg [8:0] fs_dev_desc_addr_ff,
	output reg [8:0] fs_cfg_desc_addr_ff,
	output reg [3:0] desc_present_ff,
	output reg [255:0] hub_cfg_ff,
	output wire rom_cs,
	output wire rom_clk,
	output wire rom_do,
	input wire rom_di
);
	localparam L_RESET = 3'h0;
	localparam L_ISSUE = 3'h1;
	localparam L_WAIT = 3'h2;
	localparam L_IDLE = 3'h3;
	localparam L_HISSUE = 3'h4;
	localparam L_HWAIT = 3'h5;
	localparam L_EWEN = 3'h6;
	reg [2:0] state_ff;
	reg [8:0] addr_ff;
	reg [1:0] hcmd_ff;
	reg [8:0] haddr_ff;
	reg [7:0] hwdata_ff;
	reg [7:0] len_ff;
	reg str_any_ff;
	reg wen_sent_ff;
	reg eng_start;
	reg [1:0] eng_op;
	reg [8:0] eng_addr;
	reg [7:0] eng_wdata;
	wire eng_done;
	wire [7:0] eng_rdata;
	wire eng_timeout;
	wire [8:0] hub_idx = addr_ff - `SRCL_HUB_FIRST;

	// Word offset to byte address, zero length marks absent
	function [8:0] word_to_byte;
		input [7:0] woff;
		begin
			word_to_byte = {woff, 1'b0};
		end
	endfunction

	srcl_shift #(
		.HALF_CYC(HALF_CYC),
		.BUSY_CYC(BUSY_CYC)
	) u_shift (
		.clk(clk),
		.reset(reset),
		.start(eng_start),
		.opcode(eng_op),
		.addr(eng_addr),
		.wdata(eng_wdata),
		.wait_busy(eng_op == `SRCL_OP_WRITE || eng_op == `SRCL_OP_ERASE),
		.done(eng_done),
		.rdata_ff(eng_rdata),
		.timeout_ff(eng_timeout),
		.rom_cs_ff(rom_cs),
		.rom_clk_ff(rom_clk),
		.rom_do_ff(rom_do),
		.rom_di(rom_di)
	);

	assign usb_accept = !load_busy_ff;
	assign host_ready = (state_ff == L_IDLE);

	// Engine request mux; load owns the link until idle
	always @* begin
		eng_start = 1'b0;
		eng_op = `SRCL_OP_READ;
		eng_addr = addr_ff;
		eng_wdata = hwdata_ff;
		case (state_ff)
		L_ISSUE: eng_start = 1'b1;
		L_EWEN: begin
			eng_start = 1'b1;
			eng_op = `SRCL_OP_EXT;
			eng_addr = `SRCL_EWEN_ADDR;
		end
		L_HISSUE: begin
			eng_start = 1'b1;
			eng_op = (hcmd_ff == `SRCL_CMD_WRITE) ? `SRCL_OP_WRITE :
				(hcmd_ff == `SRCL_CMD_ERASE) ? `SRCL_OP_ERASE : `SRCL_OP_READ;
			eng_addr = haddr_ff;
		end
		default: eng_start = 1'b0;
		endcase
	end

	// Load sequencer and host command handling
	always @(posedge clk) begin
		if (reset) begin
			state_ff <= L_RESET;
			addr_ff <= 9'h000;
			hcmd_ff <= 2'h0;
			haddr_ff <= 9'h000;
			hwdata_ff <= 8'h00;
			len_ff <= 8'h00;
			str_any_ff <= 1'b0;
			wen_sent_ff <= 1'b0;
			host_done_ff <= 1'b0;
			host_rdata_ff <= 8'h00;
			host_err_ff <= 1'b0;
			load_busy_ff <= 1'b1;
			image_valid_ff <= 1'b0;
			station_addr_low_reg <= 32'h00000000;
			station_addr_high_reg <= 16'h0000;
			cfg_flags_ff <= 8'h00;
			cfg_attributes_ff <= 8'h80;
			cfg_max_power_ff <= 8'h00;
			lang_id_supported_ff <= 1'b0;
			hs_dev_desc_addr_ff <= 9'h000;
			hs_cfg_desc_addr_ff <= 9'h000;
			fs_dev_desc_addr_ff <= 9'h000;
			fs_cfg_desc_addr_ff <= 9'h000;
			desc_present_ff <= 4'h0;
			hub_cfg_ff <= 256'h0;
		end else begin
			host_done_ff <= 1'b0;
			case (state_ff)
			L_RESET: begin
				addr_ff <= `SRCL_SIG_ADDR;
				hub_cfg_ff <= HUB_DEFAULT;
				state_ff <= L_ISSUE;
			end
			L_ISSUE: state_ff <= L_WAIT;
			L_WAIT: begin
				if (eng_done) begin
					state_ff <= L_ISSUE;
					addr_ff <= addr_ff + 9'h001;
					if (addr_ff == `SRCL_SIG_ADDR) begin
						// No signature: keep defaults, station address unloaded
						image_valid_ff <= (eng_rdata == `SRCL_SIG_VALUE);
						if (eng_rdata != `SRCL_SIG_VALUE) begin
							state_ff <= L_IDLE;
							load_busy_ff <= 1'b0;
						end
					end else if (addr_ff <= 9'h004) begin
						station_addr_low_reg <= {eng_rdata, station_addr_low_reg[31:8]};
					end else if (addr_ff <= 9'h006) begin
						station_addr_high_reg <= {eng_rdata, station_addr_high_reg[15:8]};
					end else if (addr_ff == `SRCL_FLAGS_ADDR) begin
						cfg_flags_ff <= eng_rdata;
						cfg_attributes_ff <= {1'b1, eng_rdata[`SRCL_FLAG_SELF], eng_rdata[`SRCL_FLAG_WAKE], 5'h00};
						cfg_max_power_ff <= eng_rdata[`SRCL_FLAG_SELF] ? 8'h01 : 8'hFA;
					end else if (addr_ff >= `SRCL_STR_FIRST && addr_ff <= `SRCL_STR_LAST) begin
						if (!addr_ff[0] && eng_rdata != 8'h00) begin
							str_any_ff <= 1'b1;
						end
					end else if (addr_ff >= 9'h016 && addr_ff <= 9'h01D) begin
						if (!addr_ff[0]) begin
							len_ff <= eng_rdata;
						end else begin
							desc_present_ff[addr_ff[2:1] - 2'h3] <= (len_ff == `SRCL_DESC_LEN);
							case (addr_ff[3:0])
							4'h7: hs_dev_desc_addr_ff <= word_to_byte(eng_rdata);
							4'h9: hs_cfg_desc_addr_ff <= word_to_byte(eng_rdata);
							4'hB: fs_dev_desc_addr_ff <= word_to_byte(eng_rdata);
							default: fs_cfg_desc_addr_ff <= word_to_byte(eng_rdata);
							endcase
						end
					end else if (addr_ff >= `SRCL_HUB_FIRST) begin
						hub_cfg_ff[hub_idx[4:0] * 8 +: 8] <= eng_rdata;
					end
					if (addr_ff == `SRCL_LOAD_LAST) begin
						lang_id_supported_ff <= str_any_ff;
						state_ff <= L_IDLE;
						load_busy_ff <= 1'b0;
					end
				end
			end
			L_IDLE: begin
				if (host_req) begin
					hcmd_ff <= host_cmd;
					haddr_ff <= host_addr;
					hwdata_ff <= host_wdata;
					state_ff <= (host_cmd == `SRCL_CMD_READ) ? L_HISSUE : L_EWEN;
				end
			end
			L_EWEN: state_ff <= L_HWAIT;
			L_HISSUE: state_ff <= L_HWAIT;
			L_HWAIT: begin
				if (eng_done) begin
					if (hcmd_ff != `SRCL_CMD_READ && !wen_sent_ff) begin
						// After write enable, issue the real command
						wen_sent_ff <= 1'b1;
						state_ff <= L_HISSUE;
					end else begin
						wen_sent_ff <= 1'b0;
						state_ff <= L_IDLE;
						host_rdata_ff <= eng_rdata;
						host_err_ff <= eng_timeout;
						host_done_ff <= 1'b1;
					end
				end
			end
			default: state_ff <= L_IDLE;
			endcase
		end
	end
endmodule

/* srcl_loader_assertions.sv */
// Port checks for the serial configuration ROM loader
`timescale 1ns/1ps
module srcl_chk #(
	parameter [255:0] HUB_DEFAULT = 256'h0
) (
	input wire clk,
	input wire reset,
	input wire host_req,
	input wire host_ready,
	input wire host_done_ff,
	input wire load_busy_ff,
	input wire usb_accept,
	input wire image_valid_ff,
	input wire [255:0] hub_cfg_ff,
	input wire rom_cs,
	input wire rom_clk
);
	reg [5:0] bits_ff = 6'h00;
	reg sclk_ff = 1'b0;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Serial clock rises per frame, seen one cycle late
	always @(posedge clk) begin
		sclk_ff <= rom_clk;
		if (reset || !rom_cs)
			bits_ff <= 6'h00;
		else if (rom_clk && !sclk_ff)
			bits_ff <= bits_ff + 6'h01;
	end
	// Frame ends only after the last rise has landed
	chk_frame_bits: assert property (load_busy_ff && $fell(rom_cs) |-> bits_ff == 6'h14)
		else $error("load frame bit count wrong");
	chk_load_start: assert property ($fell(reset) |-> load_busy_ff && !usb_accept && !rom_cs)
		else $error("load not pending after reset");
	chk_usb_hold: assert property (usb_accept == !load_busy_ff)
		else $error("usb accept disagrees with load");
	chk_usb_order: assert property ($rose(usb_accept) |-> host_ready && !rom_cs)
		else $error("usb accepted before load end");
	chk_load_holdoff: assert property (load_busy_ff |-> !host_ready)
		else $error("host ready during load");
	chk_take_busy: assert property (host_req && host_ready |=> !host_ready)
		else $error("ready after taken request");
	chk_done_pulse: assert property (host_done_ff |=> !host_done_ff)
		else $error("done longer than one cycle");
	chk_done_idle: assert property (host_done_ff |-> !rom_cs)
		else $error("done while rom selected");
	chk_hub_default: assert property ($fell(load_busy_ff) |=> image_valid_ff || hub_cfg_ff == HUB_DEFAULT)
		else $error("hub defaults missing");
	// Main scenarios reached
	cover property ($fell(load_busy_ff) && image_valid_ff);
	cover property ($fell(load_busy_ff) && !image_valid_ff);
	cover property (host_done_ff);
endmodule
bind srcl_loader srcl_chk #(.HUB_DEFAULT(HUB_DEFAULT)) u_chk (.*);

/* srcl_rom_model.sv */
// Behavioural three-wire serial ROM of 512 bytes
`timescale 1ns/1ps
module srcl_rom_model (
	input wire clk,
	input wire rom_cs,
	input wire rom_clk,
	input wire rom_do,
	output reg rom_di = 1'b0
);
	reg [7:0] mem [0:511];
	reg [19:0] sr;
	reg [7:0] rd;
	integer n = 0;
	reg we = 0;
	reg rd_on = 0;
	time rdy_t = 0;
	// New frame on select
	always @(posedge rom_cs) begin
		n = 0;
		rd_on = 0;
	end
	// Byte array behind nine address bits
	always @(posedge rom_clk) if (rom_cs) begin
		sr = {sr[18:0], rom_do};
		n = n + 1;
		if (n == 12) begin
			rd = mem[sr[8:0]];
			rd_on = sr[10:9] == 2'h2;
			if (sr[10:9] == 2'h0)
				we = sr[8:7] == 2'h3;
			if (sr[10:9] == 2'h3 && we) begin
				mem[sr[8:0]] = 8'hFF;
				rdy_t = $time + 80;
			end
		end
		if (n == 20 && sr[18:17] == 2'h1 && we) begin
			mem[sr[16:8]] = sr[7:0];
			rdy_t = $time + 80;
		end
	end
	// Idle line wanders so a stale bit never reads as data
	always @(negedge clk) begin
		if (!rom_cs)
			rom_di <= ~rom_di;
		else if ($time < rdy_t)
			rom_di <= 1'b0;
		else if (rd_on && n >= 12 && n < 20)
			rom_di <= rd[19 - n];
		else
			rom_di <= n == 0 || n >= 20;
	end
endmodule

/* srcl_loader_bench.sv */
// Self-checking bench for the serial configuration ROM loader
`timescale 1ns/1ps
`include "srcl_consts.vh"
module srcl_loader_bench;
	localparam [255:0] HDEF = {32{8'h5A}};
	reg clk = 0;
	reg reset = 1;
	reg host_req = 0;
	reg [1:0] host_cmd = 0;
	reg [8:0] host_addr = 0;
	reg [7:0] host_wdata = 0;
	wire host_ready, host_done_ff, host_err_ff, load_busy_ff, usb_accept, image_valid_ff, lang_id_supported_ff;
	wire rom_cs, rom_clk, rom_do, rom_di;
	wire [7:0] host_rdata_ff, cfg_flags_ff, cfg_max_power_ff;
	wire [31:0] station_addr_low_reg;
	wire [15:0] station_addr_high_reg;
	wire [7:0] cfg_attributes_ff;
	wire [8:0] hs_dev_desc_addr_ff, hs_cfg_desc_addr_ff, fs_dev_desc_addr_ff, fs_cfg_desc_addr_ff;
	wire [3:0] desc_present_ff;
	wire [255:0] hub_cfg_ff;
	integer err_total = 0, n_compared = 0, i, k;
	reg [7:0] seed = 8'h4D;
	reg [255:0] hx;
	srcl_loader #(.HALF_CYC(4), .BUSY_CYC(20), .HUB_DEFAULT(HDEF)) dut (.*);
	srcl_rom_model rom (.*);
	always #5 clk = ~clk;
	function [7:0] lfsr(input [7:0] s);
		lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task chk(input [255:0] e, input [255:0] g, input [63:0] w);
		begin
			n_compared = n_compared + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("[ERR] %0s exp %0h got %0h", w, e, g);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_total);
			if (err_total == 0 && n_compared > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// Random image; descriptor lengths only 0 or 18
	task img(input [7:0] sig, input [7:0] hl, input [7:0] cl, input [7:0] sl, input [7:0] fl);
		begin
			// All but the top byte filled so no read returns unknowns; top byte kept for the refusal test
			for (i = 0; i < 511; i = i + 1) begin
				seed = lfsr(seed);
				rom.mem[i] = seed;
			end
			// Strings absent, so no index refers to them
			for (i = 12; i < 30; i = i + 2)
				rom.mem[i] = 8'h00;
			{rom.mem[0], rom.mem[9], rom.mem[12]} = {sig, fl, sl};
			{rom.mem[22], rom.mem[26], rom.mem[24], rom.mem[28]} = {hl, hl, cl, cl};
		end
	endtask
	// Reset, optional refused request, bounded wait for load end
	task boot(input poke);
		begin
			@(negedge clk) reset = 1;
			repeat (2) @(negedge clk);
			reset = 0;
			{host_req, host_cmd, host_addr, host_wdata} = {poke, 2'h1, 9'h1FF, 8'h00};
			@(negedge clk) host_req = 0;
			chk(1'b0, usb_accept, "accept");
			for (k = 0; k < 20000 && load_busy_ff !== 1'b0; k = k + 1)
				@(negedge clk);
			chk(1'b1, usb_accept, "acc_end");
		end
	endtask
	task hop(input [1:0] c, input [8:0] a, input [7:0] d);
		begin
			@(negedge clk);
			while (host_ready !== 1'b1)
				@(negedge clk);
			{host_req, host_cmd, host_addr, host_wdata} = {1'b1, c, a, d};
			@(negedge clk) host_req = 0;
			for (k = 0; k < 5000 && host_done_ff !== 1'b1; k = k + 1)
				@(negedge clk);
			chk(1'b1, host_done_ff, "done");
			chk(1'b0, host_err_ff, "err");
		end
	endtask
	task verify(input v);
		begin
			chk(v, image_valid_ff, "valid");
			// Only bytes 20h to 39h are hub parameters; the rest keep defaults
			for (i = 0; i < 32; i = i + 1)
				hx[8 * i +: 8] = (v && i < 26) ? rom.mem[32 + i] : HDEF[8 * i +: 8];
			chk(hx, hub_cfg_ff, "hub");
			if (v) begin
				chk({rom.mem[4], rom.mem[3], rom.mem[2], rom.mem[1]}, station_addr_low_reg, "st_lo");
				chk({rom.mem[6], rom.mem[5]}, station_addr_high_reg, "st_hi");
				chk(rom.mem[9], cfg_flags_ff, "flags");
				chk({rom.mem[23], 1'b0}, hs_dev_desc_addr_ff, "hs_dev");
				chk({rom.mem[25], 1'b0}, hs_cfg_desc_addr_ff, "hs_cfg");
				chk({rom.mem[27], 1'b0}, fs_dev_desc_addr_ff, "fs_dev");
				chk({rom.mem[29], 1'b0}, fs_cfg_desc_addr_ff, "fs_cfg");
				k = rom.mem[22] == 8'h12;
				i = rom.mem[24] == 8'h12;
				chk({i[0], k[0], i[0], k[0]}, desc_present_ff, "present");
				chk(|rom.mem[12], lang_id_supported_ff, "lang");
				if (i == 0) begin
					chk(rom.mem[9][0] ? 8'h01 : 8'hFA, cfg_max_power_ff, "maxpwr");
					chk({1'b1, rom.mem[9][0], rom.mem[9][2], 5'h00}, cfg_attributes_ff, "attr");
				end
			end else begin
				// Nothing loaded; host software owns the station address
				chk(48'h0, {station_addr_high_reg, station_addr_low_reg}, "st_none");
			end
			$display("image test done");
		end
	endtask
	initial begin
		img(`SRCL_SIG_VALUE, 8'h12, 8'h00, 8'h00, 8'h01);
		boot(0);
		verify(1);
		seed = lfsr(seed);
		hop(`SRCL_CMD_WRITE, 9'h1FF, seed);
		chk(seed, rom.mem[511], "wr_mem");
		hop(`SRCL_CMD_READ, 9'h1FF, 8'h00);
		chk(seed, host_rdata_ff, "rd_top");
		hop(`SRCL_CMD_ERASE, 9'h1FF, 8'h00);
		chk(8'hFF, rom.mem[511], "erase");
		repeat (4) begin
			seed = lfsr(seed);
			hop(`SRCL_CMD_READ, {seed[0], seed}, 8'h00);
			chk(rom.mem[{seed[0], seed}], host_rdata_ff, "rd_rand");
		end
		$display("host access test done");
		img(`SRCL_SIG_VALUE, 8'h00, 8'h12, 8'h0A, 8'h04);
		boot(1);
		verify(1);
		chk(8'hFF, rom.mem[511], "refused");
		img(8'h5A, 8'h12, 8'h00, 8'h00, 8'h00);
		boot(0);
		verify(0);
		report_and_stop;
	end
	// Watchdog sized well above three loads and host traffic
	initial begin
		#700000;
		err_total = err_total + 1;
		report_and_stop;
	end
endmodule
